// ### design/mie_defs.vh
`ifndef MIE_DEFS_VH
`define MIE_DEFS_VH

// Register offsets
`define MIE_ADDR_LO        8'h40
`define MIE_ADDR_HI        8'h71
`define MIE_ADDR_RO_HI     8'h4a
`define MIE_ADDR_X_LSB     8'h42
`define MIE_ADDR_X_MSB     8'h43
`define MIE_ADDR_Y_LSB     8'h44
`define MIE_ADDR_Y_MSB     8'h45
`define MIE_ADDR_Z_LSB     8'h46
`define MIE_ADDR_Z_MSB     8'h47
`define MIE_ADDR_R_LSB     8'h48
`define MIE_ADDR_R_MSB     8'h49
`define MIE_ADDR_STATUS    8'h4a
`define MIE_ADDR_AXIS_EN   8'h4d
`define MIE_ADDR_PIN_CTL   8'h4e
`define MIE_ADDR_LOWER     8'h4f
`define MIE_ADDR_UPPER     8'h50

// Field positions
`define MIE_ST_OVERRUN     7
`define MIE_ST_SATURATE    6
`define MIE_EN_OVERRUN     7
`define MIE_EN_SATURATE    6
`define MIE_PC_READY_PIN   7
`define MIE_PC_IRQ_PIN     6
`define MIE_PC_READY_LVL   2
`define MIE_PC_HOLD        1
`define MIE_PC_IRQ_LVL     0
`define MIE_PC_WR_MASK     8'hc7

// Reset values
`define MIE_RST_AXIS_EN    8'h3f
`define MIE_RST_PIN_CTL    8'h07
`define MIE_RST_LOWER      8'h00
`define MIE_RST_UPPER      8'h00
`define MIE_RST_STATUS     8'h00

// Saturation codes
`define MIE_SAT_XY         13'h1000
`define MIE_SAT_Z          15'h4000

`endif

// ### design/mie_data_store.v
`timescale 1ns/10ps
`include "mie_defs.vh"

module mie_data_store (
    input wire clk,               // System clock
    input wire rst_n,             // Synchronous reset
    input wire store,             // Commit a measurement set
    input wire [12:0] raw_x,      // Raw X result
    input wire [12:0] raw_y,      // Raw Y result
    input wire [14:0] raw_z,      // Raw Z result
    input wire [13:0] raw_r,      // Raw hall resistance
    input wire [2:0] ovf,         // Per-axis overflow, bit0 = X
    output wire [12:0] sat_x,     // Saturated X, combinational
    output wire [12:0] sat_y,     // Saturated Y, combinational
    output wire [14:0] sat_z,     // Saturated Z, combinational
    output reg [12:0] axis_x_value, // Stored X
    output reg [12:0] axis_y_value, // Stored Y
    output reg [14:0] axis_z_value, // Stored Z
    output reg [13:0] hall_resistance_value // Stored hall value
);

assign sat_x = ovf[0] ? `MIE_SAT_XY : raw_x;
assign sat_y = ovf[1] ? `MIE_SAT_XY : raw_y;
assign sat_z = ovf[2] ? `MIE_SAT_Z : raw_z;

// All four values land together so a reader never sees a mixed set
always @(posedge clk)
begin
    if (!rst_n)
    begin
        axis_x_value <= 13'h0000;
        axis_y_value <= 13'h0000;
        axis_z_value <= 15'h0000;
        hall_resistance_value <= 14'h0000;
    end
    else if (store)
    begin
        axis_x_value <= sat_x;
        axis_y_value <= sat_y;
        axis_z_value <= sat_z;
        hall_resistance_value <= raw_r;
    end
end

endmodule

// ### design/mie_pin_drive.v
`timescale 1ns/10ps

module mie_pin_drive (
    input wire clk,               // System clock
    input wire rst_n,             // Synchronous reset
    input wire enable,            // Pin driven push-pull when high
    input wire active_high,       // 1 = active high, 0 = active low
    input wire event_on,          // Interrupt condition present
    output reg pin_o,             // Pin output level
    output reg pin_oe             // Pin output enable
);

always @(posedge clk)
begin
    if (!rst_n)
    begin
        pin_o <= 1'b0;
        pin_oe <= 1'b0;
    end
    else
    begin
        pin_oe <= enable;
        pin_o <= enable & (event_on ~^ active_high);
    end
end

endmodule

// ### design/mie_top.v
`timescale 1ns/10ps
`include "mie_defs.vh"

// Function
// - Hold mode covers threshold and overflow only
// - Data ready clears after data readout ends
// - Non-latched flags follow each new measurement
// - Latched flags clear on status register read
// - Bit1 selects latched, resets to latched
// - Bit0 and bit2 select pin polarities
// - Pins push-pull when enabled, else floating
// - Data ready after full four-value set stored
// - Data ready non-latched, pin enable bit7
// - Per-axis low flag when below low level
// - X/Y saturation code gives no low flag
// - Pin shows enabled axes below low level
// - Axis threshold enables are active low
// - Per-axis high flag when above high level
// - High pin: OR of enabled axes above 16x
// - Overflowed axis saturates to most negative
// - Shared saturation flag at status bit6
// - Saturation reaches pin only if enabled
// - 8-bit registers 0x40..0x71, reserved ignored
// - Registers up to status are read-only
// - Data output may float on reserved reads
// - Status updates with the data store
// - Threshold pin needs pin enable bit6
// - Axis enables sit in bits five to zero

module mie_top (
    input wire clk,               // 100 MHz system clock
    input wire rst_n,             // Synchronous reset, active low
    input wire meas_done,         // One-cycle pulse, measurement complete
    input wire [12:0] meas_x,     // Raw X result, signed
    input wire [12:0] meas_y,     // Raw Y result, signed
    input wire [14:0] meas_z,     // Raw Z result, signed
    input wire [13:0] meas_hall_resistance_value, // Raw hall resistance
    input wire [2:0] meas_ovf,    // Per-axis overflow, bit0 = X
    input wire [7:0] reg_addr,    // Register address
    input wire reg_wr,            // Write strobe, one cycle
    input wire [7:0] reg_wdata,   // Write data
    input wire reg_rd,            // Read strobe, one cycle
    input wire read_end,          // Pulse, host read sequence finished
    output reg [7:0] reg_rdata,   // Read data, one cycle after reg_rd
    output reg reg_rdata_drive,   // High when read data is driven
    output wire int_pin_o,        // Threshold interrupt pin level
    output wire int_pin_oe,       // Threshold interrupt pin enable
    output wire data_ready_pin_o, // Data-ready pin level
    output wire data_ready_pin_oe // Data-ready pin enable
);

// ********************************************************
// Declarations
// ********************************************************
reg [7:0] irq_status_flags;
reg [7:0] irq_axis_enable;
reg [7:0] irq_pin_control;
reg [7:0] lower_limit_level;
reg [7:0] upper_limit_level;
reg data_ready;
reg data_read_seen;
reg [7:0] next_rdata;
reg next_drive;
reg [6:0] next_flags;

wire [12:0] sat_x;
wire [12:0] sat_y;
wire [14:0] sat_z;
wire [12:0] axis_x_value;
wire [12:0] axis_y_value;
wire [14:0] axis_z_value;
wire [13:0] hall_resistance_value;
wire [47:0] axis_vals;
wire [15:0] lower_x16;
wire [15:0] upper_x16;
wire [2:0] below_hit;
wire [2:0] above_hit;
wire [2:0] below_axis_enable_n;
wire [2:0] above_axis_enable_n;
wire [6:0] new_flags;
wire hold_mode;
wire status_read;
wire data_reg_read;
wire wr_ok;
wire irq_event;
wire overflow_any;

// ********************************************************
// Data registers
// ********************************************************
mie_data_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .store(meas_done),
    .raw_x(meas_x),
    .raw_y(meas_y),
    .raw_z(meas_z),
    .raw_r(meas_hall_resistance_value),
    .ovf(meas_ovf),
    .sat_x(sat_x),
    .sat_y(sat_y),
    .sat_z(sat_z),
    .axis_x_value(axis_x_value),
    .axis_y_value(axis_y_value),
    .axis_z_value(axis_z_value),
    .hall_resistance_value(hall_resistance_value)
);

// ********************************************************
// Threshold comparison
// ********************************************************
// Compare against the incoming set so flags and data commit together
assign axis_vals = {sat_z[14], sat_z,
                    {3{sat_y[12]}}, sat_y,
                    {3{sat_x[12]}}, sat_x};

// Levels are signed, one step is 16 raw counts
assign lower_x16 = {{4{lower_limit_level[7]}}, lower_limit_level,
                    4'h0};
assign upper_x16 = {{4{upper_limit_level[7]}}, upper_limit_level,
                    4'h0};

assign below_axis_enable_n = irq_axis_enable[2:0];
assign above_axis_enable_n = irq_axis_enable[5:3];

genvar i;
generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_axis
        wire signed [15:0] v;
        wire sat_code;
        assign v = axis_vals[16*i+15:16*i];
        // Only X and Y carry the overflow code into the low test
        if (i < 2)
        begin : g_xy
            assign sat_code = meas_ovf[i];
        end
        else
        begin : g_z
            assign sat_code = 1'b0;
        end
        assign below_hit[i] = (v < $signed(lower_x16)) & ~sat_code;
        assign above_hit[i] = v > $signed(upper_x16);
    end
endgenerate

// Saturation is flagged whatever the enables say; the saturation
// enable only decides whether it reaches the pin
assign overflow_any = |meas_ovf;
assign new_flags = {overflow_any,
                    above_hit & ~above_axis_enable_n,
                    below_hit & ~below_axis_enable_n};

// ********************************************************
// Register access decode
// ********************************************************
assign hold_mode = irq_pin_control[`MIE_PC_HOLD];
assign status_read = reg_rd && (reg_addr == `MIE_ADDR_STATUS);
assign data_reg_read = reg_rd && (reg_addr >= `MIE_ADDR_X_LSB) &&
                       (reg_addr <= `MIE_ADDR_R_MSB);
// Nothing at or below the status register accepts a write
assign wr_ok = reg_wr && (reg_addr > `MIE_ADDR_RO_HI) &&
               (reg_addr <= `MIE_ADDR_HI);

// ********************************************************
// Writable control registers
// ********************************************************
always @(posedge clk)
begin
    if (!rst_n)
    begin
        irq_axis_enable <= `MIE_RST_AXIS_EN;
        irq_pin_control <= `MIE_RST_PIN_CTL;
        lower_limit_level <= `MIE_RST_LOWER;
        upper_limit_level <= `MIE_RST_UPPER;
    end
    else if (wr_ok)
    begin
        case (reg_addr)
            `MIE_ADDR_AXIS_EN:
                irq_axis_enable <= reg_wdata;
            // Bits 5..3 of pin control are reserved and stay zero
            `MIE_ADDR_PIN_CTL:
                irq_pin_control <= reg_wdata & `MIE_PC_WR_MASK;
            `MIE_ADDR_LOWER:
                lower_limit_level <= reg_wdata;
            `MIE_ADDR_UPPER:
                upper_limit_level <= reg_wdata;
            default:
                irq_pin_control <= irq_pin_control;
        endcase
    end
end

// ********************************************************
// Interrupt status flags
// ********************************************************
// A status read and a new set in one cycle keep the new flags, so
// no event is lost to the clear in latched mode
always @*
begin
    next_flags = irq_status_flags[6:0];
    if (hold_mode && status_read)
        next_flags = 7'h00;
    if (meas_done)
    begin
        if (hold_mode)
            next_flags = next_flags | new_flags;
        else
            next_flags = new_flags;
    end
end

// A measurement in the clearing cycle still sets its flags
always @(posedge clk)
begin
    if (!rst_n)
        irq_status_flags <= `MIE_RST_STATUS;
    else
    begin
        irq_status_flags[6:0] <= next_flags;
        if (meas_done && data_ready &&
            irq_axis_enable[`MIE_EN_OVERRUN])
            irq_status_flags[`MIE_ST_OVERRUN] <= 1'b1;
        else if (status_read)
            irq_status_flags[`MIE_ST_OVERRUN] <= 1'b0;
    end
end

// ********************************************************
// Data ready
// ********************************************************
// Never held by the latch mode: only a finished readout clears it
// A data read is remembered so a later end of burst still clears it
always @(posedge clk)
begin
    if (!rst_n)
    begin
        data_ready <= 1'b0;
        data_read_seen <= 1'b0;
    end
    else
    begin
        if (meas_done)
            data_ready <= 1'b1;
        else if (read_end && (data_read_seen || data_reg_read))
            data_ready <= 1'b0;
        if (read_end)
            data_read_seen <= 1'b0;
        else if (data_reg_read)
            data_read_seen <= 1'b1;
    end
end

// ********************************************************
// Read path
// ********************************************************
always @*
begin
    next_drive = 1'b1;
    case (reg_addr)
        `MIE_ADDR_X_LSB:
            next_rdata = {axis_x_value[4:0], 3'h0};
        `MIE_ADDR_X_MSB:
            next_rdata = axis_x_value[12:5];
        `MIE_ADDR_Y_LSB:
            next_rdata = {axis_y_value[4:0], 3'h0};
        `MIE_ADDR_Y_MSB:
            next_rdata = axis_y_value[12:5];
        `MIE_ADDR_Z_LSB:
            next_rdata = {axis_z_value[6:0], 1'b0};
        `MIE_ADDR_Z_MSB:
            next_rdata = axis_z_value[14:7];
        `MIE_ADDR_R_LSB:
            next_rdata = {hall_resistance_value[5:0], 1'b0, data_ready};
        `MIE_ADDR_R_MSB:
            next_rdata = hall_resistance_value[13:6];
        `MIE_ADDR_STATUS:
            next_rdata = irq_status_flags;
        `MIE_ADDR_AXIS_EN:
            next_rdata = irq_axis_enable;
        `MIE_ADDR_PIN_CTL:
            next_rdata = irq_pin_control;
        `MIE_ADDR_LOWER:
            next_rdata = lower_limit_level;
        `MIE_ADDR_UPPER:
            next_rdata = upper_limit_level;
        default:
        begin
            // Reserved space floats the data line
            next_rdata = 8'h00;
            next_drive = 1'b0;
        end
    endcase
end

always @(posedge clk)
begin
    if (!rst_n)
    begin
        reg_rdata <= 8'h00;
        reg_rdata_drive <= 1'b0;
    end
    // Data stands from the cycle after the strobe until the next read;
    // the drive flag stands for that one cycle only
    else if (reg_rd)
    begin
        reg_rdata <= next_rdata;
        reg_rdata_drive <= next_drive;
    end
    else
        reg_rdata_drive <= 1'b0;
end

// ********************************************************
// Interrupt pins
// ********************************************************
// Saturation shares the pin with the thresholds; data ready does not
// Overrun is host bookkeeping only and stays off the pin
assign irq_event = (|irq_status_flags[5:0]) |
                   (irq_status_flags[`MIE_ST_SATURATE] &
                    irq_axis_enable[`MIE_EN_SATURATE]);

mie_pin_drive u_int_pin (
    .clk(clk),
    .rst_n(rst_n),
    .enable(irq_pin_control[`MIE_PC_IRQ_PIN]),
    .active_high(irq_pin_control[`MIE_PC_IRQ_LVL]),
    .event_on(irq_event),
    .pin_o(int_pin_o),
    .pin_oe(int_pin_oe)
);

mie_pin_drive u_ready_pin (
    .clk(clk),
    .rst_n(rst_n),
    .enable(irq_pin_control[`MIE_PC_READY_PIN]),
    .active_high(irq_pin_control[`MIE_PC_READY_LVL]),
    .event_on(data_ready),
    .pin_o(data_ready_pin_o),
    .pin_oe(data_ready_pin_oe)
);

endmodule

// ### bench/mie_top_props.sv
`timescale 1ns/10ps
// ****************************************
// Port checker for the interrupt engine
// ****************************************
module mie_top_checker (
    input wire clk, // System clock
    input wire rst_n, // Synchronous reset, active low
    input wire [7:0] reg_addr, // Register address
    input wire reg_wr, // Write strobe
    input wire [7:0] reg_wdata, // Write data
    input wire reg_rd, // Read strobe
    input wire read_end, // Read sequence finished
    input wire [7:0] reg_rdata, // Read data
    input wire reg_rdata_drive, // Read data driven
    input wire int_pin_o, // Threshold pin level
    input wire int_pin_oe, // Threshold pin enable
    input wire data_ready_pin_o, // Data-ready pin level
    input wire data_ready_pin_oe // Data-ready pin enable
);
    wire mapped;
    assign mapped = (reg_addr >= 8'h42 && reg_addr <= 8'h4a) ||
                    (reg_addr >= 8'h4d && reg_addr <= 8'h50);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_rd_mapped;
        reg_rd && mapped |=> reg_rdata_drive;
    endproperty
    a_rd_mapped: assert property (p_rd_mapped)
        else $error("mapped read not driven");
    property p_rd_reserved;
        reg_rd && !mapped |=> !reg_rdata_drive && reg_rdata == 8'h00;
    endproperty
    a_rd_reserved: assert property (p_rd_reserved)
        else $error("reserved read driven");
    property p_drive_pulse;
        !reg_rd |=> !reg_rdata_drive;
    endproperty
    a_drive_pulse: assert property (p_drive_pulse)
        else $error("read data driven without a read");
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");
    property p_int_oe;
        reg_wr && reg_addr == 8'h4e |=> ##1
            int_pin_oe == $past(reg_wdata[6], 2);
    endproperty
    a_int_oe: assert property (p_int_oe)
        else $error("threshold pin enable wrong");
    property p_ready_oe;
        reg_wr && reg_addr == 8'h4e |=> ##1
            data_ready_pin_oe == $past(reg_wdata[7], 2);
    endproperty
    a_ready_oe: assert property (p_ready_oe)
        else $error("data-ready pin enable wrong");
    property p_int_float;
        !int_pin_oe |-> !int_pin_o;
    endproperty
    a_int_float: assert property (p_int_float)
        else $error("threshold pin level while floating");
    property p_ready_float;
        !data_ready_pin_oe |-> !data_ready_pin_o;
    endproperty
    a_ready_float: assert property (p_ready_float)
        else $error("data-ready pin level while floating");
    property p_reset_off;
        $rose(rst_n) |-> !int_pin_oe && !data_ready_pin_oe &&
            !reg_rdata_drive;
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("pins driven after reset");
    c_status_read: cover property (reg_rd && reg_addr == 8'h4a);
    c_int_active: cover property (int_pin_oe && int_pin_o);
    c_read_end: cover property (read_end ##2 data_ready_pin_oe);
    c_reserved: cover property (reg_rd && !mapped);
endmodule

bind mie_top mie_top_checker u_mie_top_checker (.clk, .rst_n, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rd, .read_end, .reg_rdata, .reg_rdata_drive,
    .int_pin_o, .int_pin_oe, .data_ready_pin_o, .data_ready_pin_oe);

// ### bench/mie_host_model.sv
`timescale 1ns/10ps
// ****************************************
// Host side of the register port
// ****************************************
module mie_host_model (
    input wire clk, // System clock
    input wire [7:0] reg_rdata, // Read data from the device
    input wire reg_rdata_drive, // Read data driven
    output logic [7:0] reg_addr, // Register address
    output logic reg_wr, // Write strobe
    output logic [7:0] reg_wdata, // Write data
    output logic reg_rd, // Read strobe
    output logic read_end // End of a read sequence
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        read_end = 1'b0;
    end
    task bus_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // Released data must not look like the last byte
        reg_wdata = ~d;
    endtask
    task bus_read(input logic [7:0] a, output logic [7:0] d,
                  output logic drv);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
        drv = reg_rdata_drive;
    endtask
    task end_read;
        @(negedge clk);
        read_end = 1'b1;
        @(negedge clk);
        read_end = 1'b0;
    endtask
endmodule

// ### bench/mie_top_tb.sv
`timescale 1ns/10ps
module mie_top_tb;
    logic clk, rst_n, meas_done;
    logic [12:0] meas_x, meas_y;
    logic [14:0] meas_z;
    logic [13:0] meas_hall_resistance_value;
    logic [2:0] meas_ovf;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire reg_wr, reg_rd, read_end, reg_rdata_drive;
    wire int_pin_o, int_pin_oe, data_ready_pin_o, data_ready_pin_oe;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    mie_top u_mie_top (.clk(clk), .rst_n(rst_n), .meas_done(meas_done),
        .meas_x(meas_x), .meas_y(meas_y), .meas_z(meas_z),
        .meas_hall_resistance_value(meas_hall_resistance_value), .meas_ovf(meas_ovf), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .read_end(read_end), .reg_rdata(reg_rdata),
        .reg_rdata_drive(reg_rdata_drive), .int_pin_o(int_pin_o),
        .int_pin_oe(int_pin_oe), .data_ready_pin_o(data_ready_pin_o),
        .data_ready_pin_oe(data_ready_pin_oe));
    mie_host_model u_mie_host_model (.clk(clk), .reg_rdata(reg_rdata),
        .reg_rdata_drive(reg_rdata_drive), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .read_end(read_end));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************************************
    // Shared checking and stimulus tasks
    // ****************************************
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard: the full run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            give_verdict;
        end
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        u_mie_host_model.bus_write(a, d);
    endtask
    task rdchk(input logic [7:0] a, input logic [7:0] exp, input logic drv);
        logic [7:0] d;
        logic v;
        u_mie_host_model.bus_read(a, d, v);
        check(d, exp);
        check({7'h00, v}, {7'h00, drv});
    endtask
    // Nibble order: int enable, int level, ready enable, ready level
    task pins(input logic [7:0] exp);
        @(negedge clk);
        check({4'h0, int_pin_oe, int_pin_o, data_ready_pin_oe,
               data_ready_pin_o}, exp);
    endtask
    task meas(input logic [12:0] x, input logic [12:0] y,
              input logic [14:0] z, input logic [2:0] ovf);
        @(negedge clk);
        meas_x = x;
        meas_y = y;
        meas_z = z;
        meas_ovf = ovf;
        meas_done = 1'b1;
        @(negedge clk);
        meas_done = 1'b0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        rdchk(8'h4a, 8'h00, 1'b1);
        rdchk(8'h4d, 8'h3f, 1'b1);
        rdchk(8'h4e, 8'h07, 1'b1);
        rdchk(8'h4f, 8'h00, 1'b1);
        rdchk(8'h50, 8'h00, 1'b1);
        pins(8'h00);
        $display("test reset done");
    endtask
    task t_access;
        wr(8'h4a, 8'hff);
        wr(8'h42, 8'hff);
        wr(8'h60, 8'hff);
        rdchk(8'h4a, 8'h00, 1'b1);
        rdchk(8'h42, 8'h00, 1'b1);
        wr(8'h4e, 8'hff);
        rdchk(8'h4e, 8'hc7, 1'b1);
        rdchk(8'h60, 8'h00, 1'b0);
        rdchk(8'h4c, 8'h00, 1'b0);
        pins(8'h0a);
        $display("test access done");
    endtask
    task t_latched;
        wr(8'h4d, 8'h00);
        wr(8'h4f, 8'hfe);
        wr(8'h50, 8'h02);
        wr(8'h4e, 8'hc7);
        meas(13'd33, 13'd32, 15'h7fdf, 3'b000);
        rdchk(8'h43, 8'h01, 1'b1);
        rdchk(8'h42, 8'h08, 1'b1);
        pins(8'h0f);
        meas(13'h0000, 13'h0000, 15'h0000, 3'b000);
        pins(8'h0f);
        rdchk(8'h4a, 8'h0c, 1'b1);
        pins(8'h0b);
        rdchk(8'h4a, 8'h00, 1'b1);
        $display("test latched done");
    endtask
    task t_ready;
        u_mie_host_model.end_read;
        pins(8'h0a);
        meas(13'h0000, 13'h0000, 15'h0000, 3'b000);
        pins(8'h0b);
        rdchk(8'h4a, 8'h00, 1'b1);
        u_mie_host_model.end_read;
        pins(8'h0b);
        rdchk(8'h48, 8'hfd, 1'b1);
        rdchk(8'h49, 8'hff, 1'b1);
        u_mie_host_model.end_read;
        pins(8'h0a);
        wr(8'h4e, 8'hc3);
        pins(8'h0b);
        $display("test ready done");
    endtask
    task t_nonlatch;
        wr(8'h4e, 8'hc4);
        meas(13'd33, 13'h0000, 15'h0000, 3'b000);
        pins(8'h0b);
        rdchk(8'h4a, 8'h08, 1'b1);
        rdchk(8'h4a, 8'h08, 1'b1);
        meas(13'h0000, 13'h0000, 15'h0000, 3'b000);
        pins(8'h0f);
        rdchk(8'h4a, 8'h00, 1'b1);
        $display("test non-latched done");
    endtask
    task t_ovf;
        wr(8'h4e, 8'h41);
        wr(8'h4d, 8'h40);
        meas(13'd5, 13'h0000, 15'd7, 3'b101);
        rdchk(8'h4a, 8'h44, 1'b1);
        rdchk(8'h43, 8'h80, 1'b1);
        rdchk(8'h42, 8'h00, 1'b1);
        rdchk(8'h47, 8'h80, 1'b1);
        rdchk(8'h46, 8'h00, 1'b1);
        pins(8'h0c);
        wr(8'h4d, 8'h3f);
        meas(13'd5, 13'h0000, 15'd7, 3'b001);
        rdchk(8'h4a, 8'h40, 1'b1);
        pins(8'h08);
        wr(8'h4d, 8'h7f);
        pins(8'h0c);
        wr(8'h4d, 8'hbf);
        meas(13'h0000, 13'h0000, 15'h0000, 3'b000);
        rdchk(8'h4a, 8'h80, 1'b1);
        rdchk(8'h4a, 8'h00, 1'b1);
        pins(8'h08);
        $display("test overflow done");
    endtask
    initial
    begin
        rst_n = 1'b0;
        meas_done = 1'b0;
        meas_x = 13'h0000;
        meas_y = 13'h0000;
        meas_z = 15'h0000;
        meas_hall_resistance_value = 14'h3fff;
        meas_ovf = 3'b000;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_reset;
        t_access;
        t_latched;
        t_ready;
        t_nonlatch;
        t_ovf;
        give_verdict;
    end
endmodule
